// >>> rtl/sdf_map.svh
// Purpose: register offsets, field positions and fixed figures
// Assumes: 8-bit control registers on a byte address
// Notes:   definitions only
`ifndef SDF_MAP_SVH
`define SDF_MAP_SVH
`define SDF_ADDR_GAIN    8'h05
`define SDF_ADDR_SETUP   8'h06
`define SDF_ADDR_FINE0   8'h0a
`define SDF_ADDR_FINE1   8'h0b
`define SDF_ADDR_FINE2   8'h0c
`define SDF_ADDR_FAST0   8'h0d
`define SDF_ADDR_FAST1   8'h0e
`define SDF_ADDR_FAST2   8'h0f
`define SDF_ADDR_STAT    8'h10
`define SDF_REG_RST      8'h00
`define SDF_ON_BIT       7
`define SDF_FINE_SEL     1:0
`define SDF_FAST_SEL     3:2
`define SDF_CYC_SEL      5:4
`define SDF_STAT_SHORT   0
`define SDF_STAT_ON      1
`define SDF_STAT_NEW     2
`define SDF_CYC_OFFSET   2'h0
`define SDF_CYC_CANCEL   2'h1
`define SDF_FINE_LOG2    4'hb
`define SDF_FAST_LOG2    4'h5
`define SDF_FAST_SHIFT   3'h6
`define SDF_SAT_FIELD    21:18
`define SDF_SAT_ALL      4'hf
`define SDF_SAT_LIM_WIDE 4'ha
`define SDF_SAT_LIM_NARR 4'h5
`define SDF_TRUNC_FIELD  5:1
`define SDF_TRUNC_ZERO   5'h00
`endif

// >>> rtl/sdf_pkg.sv
// Purpose: shared types of the decimation filter block
// Assumes: nothing
// Notes:   numbers live in sdf_map.svh
package sdf_pkg;
  // which half of an offset-cancel cycle is running
  typedef enum logic {SDF_PH_SHORT, SDF_PH_INPUT} sdf_phase_t;
  // output code variant of the product
  typedef enum logic [1:0] {SDF_MODEL_5K, SDF_MODEL_20K,
                            SDF_MODEL_50K} sdf_model_t;
  typedef logic [1:0] sdf_sel_t;
endpackage

// >>> rtl/sdf_regs.sv
// Purpose: control registers and read-back of results and status
// Assumes: one-cycle strobes, read data in the following cycle only
// Notes:   unmapped reads return zero, unmapped writes are dropped
`include "sdf_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sdf_regs (
  input  wire logic        clk,          // system clock
  input  wire logic        nrst,         // async reset, active low
  input  wire logic [7:0]  reg_addr,     // register address
  input  wire logic [7:0]  reg_wdata,    // write data
  input  wire logic        reg_wr,       // write strobe
  input  wire logic        reg_rd,       // read strobe
  output logic      [7:0]  reg_rdata,    // read data, cycle after rd
  output logic      [7:0]  gain_select,  // gain / enable register
  output logic      [7:0]  conv_setup,   // converter setup register
  input  wire logic [23:0] fine_result,  // latched fine result
  input  wire logic [23:0] fast_result,  // fast result, sign extended
  input  wire logic        fine_valid,   // fine result strobe
  input  wire logic        input_short   // modulator input shorted
);
  logic [7:0] gain_ff, setup_ff, rdata_ff;
  logic [7:0] nxt_gain, nxt_setup, nxt_rdata;
  logic       new_ff, nxt_new;

  // write decode, sticky flag and read mux
  always_comb
  begin
    nxt_gain  = gain_ff;
    nxt_setup = setup_ff;
    nxt_new   = new_ff;
    nxt_rdata = 8'h00;
    if (reg_wr && reg_addr == `SDF_ADDR_GAIN)
      nxt_gain = reg_wdata;
    if (reg_wr && reg_addr == `SDF_ADDR_SETUP)
      nxt_setup = reg_wdata;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `SDF_ADDR_GAIN:  nxt_rdata = gain_ff;
        `SDF_ADDR_SETUP: nxt_rdata = setup_ff;
        `SDF_ADDR_FINE0: nxt_rdata = fine_result[7:0];
        `SDF_ADDR_FINE1: nxt_rdata = fine_result[15:8];
        `SDF_ADDR_FINE2: nxt_rdata = fine_result[23:16];
        `SDF_ADDR_FAST0: nxt_rdata = fast_result[7:0];
        `SDF_ADDR_FAST1: nxt_rdata = fast_result[15:8];
        `SDF_ADDR_FAST2: nxt_rdata = fast_result[23:16];
        `SDF_ADDR_STAT:
        begin
          nxt_rdata[`SDF_STAT_SHORT] = input_short;
          nxt_rdata[`SDF_STAT_ON]    = gain_ff[`SDF_ON_BIT];
          nxt_rdata[`SDF_STAT_NEW]   = new_ff;
          nxt_new = 1'b0;
        end
        default: nxt_rdata = 8'h00;
      endcase
    end
    // a result landing on the clearing read is kept
    if (fine_valid)
      nxt_new = 1'b1;
  end

  // register stage
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gain_ff  <= `SDF_REG_RST;
      setup_ff <= `SDF_REG_RST;
      rdata_ff <= 8'h00;
      new_ff   <= 1'b0;
    end
    else
    begin
      gain_ff  <= nxt_gain;
      setup_ff <= nxt_setup;
      rdata_ff <= nxt_rdata;
      new_ff   <= nxt_new;
    end
  end

  assign reg_rdata   = rdata_ff;
  assign gain_select = gain_ff;
  assign conv_setup  = setup_ff;
endmodule
`default_nettype wire

// >>> rtl/sdf_sinc2.sv
// Purpose: second-order sinc decimator, power-of-two tap count
// Assumes: one modulator bit per smp_en, +1 for one and -1 for zero
// Notes:   restart clears state after this cycle's dump is emitted
`timescale 1ns/1ps
`default_nettype none
module sdf_sinc2 #(
  parameter int W     = 30,
  parameter int CNT_W = 14
) (
  input  wire logic                clk,      // system clock
  input  wire logic                nrst,     // async reset, active low
  input  wire logic                restart,  // drop accumulated history
  input  wire logic                smp_en,   // modulator bit present
  input  wire logic                smp_bit,  // modulator bit
  input  wire logic [3:0]          tap_log2, // taps = 2**tap_log2
  output logic signed [W-1:0]      sum,      // latched result
  output logic                     valid     // one-cycle result strobe
);
  logic signed [W-1:0] int1_ff, int2_ff, zc1_ff, zc2_ff, sum_ff;
  logic signed [W-1:0] nxt_int1, nxt_int2, nxt_zc1, nxt_zc2, nxt_sum;
  logic [CNT_W-1:0]    cnt_ff, nxt_cnt, last;
  logic                warm_ff, nxt_warm, valid_ff, nxt_valid;
  logic signed [W-1:0] x, c1;

  // two integrators at sample rate, two combs at the dump rate
  always_comb
  begin
    last      = CNT_W'((64'h1 << tap_log2) - 64'h1);
    x         = smp_bit ? W'(1) : {W{1'b1}};
    nxt_int1  = int1_ff;
    nxt_int2  = int2_ff;
    nxt_zc1   = zc1_ff;
    nxt_zc2   = zc2_ff;
    nxt_sum   = sum_ff;
    nxt_cnt   = cnt_ff;
    nxt_warm  = warm_ff;
    nxt_valid = 1'b0;
    c1        = '0;
    if (smp_en)
    begin
      nxt_int1 = int1_ff + x;
      nxt_int2 = int2_ff + nxt_int1;
      nxt_cnt  = cnt_ff + CNT_W'(1);
      if (cnt_ff == last)
      begin
        // dump every N samples puts nulls at k*fs/N
        c1        = nxt_int2 - zc1_ff;
        nxt_zc1   = nxt_int2;
        nxt_zc2   = c1;
        nxt_sum   = c1 - zc2_ff;
        nxt_valid = warm_ff;  // first dump holds a half window
        nxt_warm  = 1'b1;
        nxt_cnt   = '0;
      end
    end
    if (restart)
    begin
      nxt_int1 = '0;
      nxt_int2 = '0;
      nxt_zc1  = '0;
      nxt_zc2  = '0;
      nxt_cnt  = '0;
      nxt_warm = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      int1_ff  <= '0;
      int2_ff  <= '0;
      zc1_ff   <= '0;
      zc2_ff   <= '0;
      sum_ff   <= '0;
      cnt_ff   <= '0;
      warm_ff  <= 1'b0;
      valid_ff <= 1'b0;
    end
    else
    begin
      int1_ff  <= nxt_int1;
      int2_ff  <= nxt_int2;
      zc1_ff   <= nxt_zc1;
      zc2_ff   <= nxt_zc2;
      sum_ff   <= nxt_sum;
      cnt_ff   <= nxt_cnt;
      warm_ff  <= nxt_warm;
      valid_ff <= nxt_valid;
    end
  end

  assign sum   = sum_ff;
  assign valid = valid_ff;
endmodule
`default_nettype wire

// >>> rtl/sdf_top.sv
// Purpose: decimation back end of a one-bit sigma-delta converter
// Assumes: modulator bits arrive with mod_bit_valid on clk
// Notes:   offset cycling drives input_short toward the modulator
//
// Summary of operation
// - each filter averages the bit stream with a sinc-squared response
// - first null at sample rate over taps, nulls at its multiples
// - two independent filters: fine for precision, fast for speed
// - fine taps 2048, 4096, 8192, 16384 for select 00 to 11
// - fast taps 32, 64, 128, 256 for select 00 to 11
// - fast result updates at sample rate over fast tap count, in input halves only with setting 01
// - setting 00 shorts the input; results show negated offset
// - setting 11 gives raw conversion, offset still included
// - setting 01 gives offset-cancelled fine result
// - fine updates every N samples, every 2N with setting 01
// - fine result is 24-bit two's complement, sign in bit 23
// - fine binary point sits between bits 22 and 21
// - 5k and 50k variants saturate bits 21..18 above 1010
// - 20k variant saturates bits 21..18 above 0101
// - 5k variant forces bits 5..1 to zero
// - gain register bit 7 switches the converter on or off
// - offset cycle field sits above both tap selects
`include "sdf_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sdf_top #(
  parameter sdf_pkg::sdf_model_t MODEL  = sdf_pkg::SDF_MODEL_50K,
  parameter int                  FINE_W = 24,
  parameter int                  FAST_W = 18,
  parameter int                  ACC_W  = 31,
  parameter int                  FACC_W = 19
) (
  input  wire logic              clk,           // 125 MHz clock
  input  wire logic              nrst,          // async reset, low
  input  wire logic [7:0]        reg_addr,      // register address
  input  wire logic [7:0]        reg_wdata,     // register write data
  input  wire logic              reg_wr,        // write strobe
  input  wire logic              reg_rd,        // read strobe
  output logic      [7:0]        reg_rdata,     // read data
  input  wire logic              mod_bit,       // modulator bit
  input  wire logic              mod_bit_valid, // one bit per strobe
  output logic                   converter_on,  // modulator power
  output logic                   input_short,   // short the input
  output logic      [FINE_W-1:0] fine_result,   // fine result word
  output logic                   fine_valid,    // new fine result
  output logic      [FAST_W-1:0] fast_result,   // fast result word
  output logic                   fast_valid     // new fast result
);
  logic [7:0]          gain_select, conv_setup;
  logic [23:0]         fast_ext;
  // applied settings, updated together with a restart
  sdf_pkg::sdf_sel_t   fine_sel_ff, fast_sel_ff, cyc_ff;
  sdf_pkg::sdf_sel_t   nxt_fine_sel, nxt_fast_sel, nxt_cyc;
  logic                on_ff, nxt_on;
  sdf_pkg::sdf_phase_t phase_ff, nxt_phase;
  sdf_pkg::sdf_phase_t dump_ph_ff;  // half whose dump is on the strobes
  logic [15:0]         pcnt_ff, nxt_pcnt, phase_last;
  logic                short_ff, nxt_short;
  logic                change, flip, restart, smp_en;
  logic [3:0]          fine_log2, fast_log2;
  // fine result path
  logic signed [ACC_W-1:0]  fine_raw, off_ff, in_ff, nxt_off, nxt_in;
  logic signed [ACC_W-1:0]  fine_val;
  logic                     fine_dv, fine_take;
  logic                     have_off_ff, have_in_ff;
  logic                     nxt_have_off, nxt_have_in;
  logic [FINE_W-1:0]        fine_out_ff, nxt_fine_out;
  logic                     fine_vld_ff, nxt_fine_vld;
  // fast result path
  logic signed [FACC_W-1:0] fast_raw;
  logic                     fast_dv;
  logic [FAST_W-1:0]        fast_out_ff, nxt_fast_out;
  logic                     fast_vld_ff, nxt_fast_vld;

  // scale to the fixed point word, then apply the variant's code
  function automatic logic [FINE_W-1:0] fine_fmt(
    input logic signed [ACC_W-1:0] v,
    input sdf_pkg::sdf_sel_t       sel
  );
    logic signed [ACC_W-1:0] sh;
    logic        [ACC_W-1:0] mag;
    logic        [FINE_W-1:0] m;
    logic        [3:0]        lim;
    // 2**(2k) full scale lands on bit 22 after a 2*sel shift
    sh  = v >>> {sel, 1'b0};
    mag = sh[ACC_W-1] ? ACC_W'(-sh) : ACC_W'(sh);
    m   = mag[FINE_W-1:0];
    if (MODEL == sdf_pkg::SDF_MODEL_20K)
      lim = `SDF_SAT_LIM_NARR;
    else
      lim = `SDF_SAT_LIM_WIDE;
    if (m[`SDF_SAT_FIELD] > lim)
      m[`SDF_SAT_FIELD] = `SDF_SAT_ALL;
    if (MODEL == sdf_pkg::SDF_MODEL_5K)
      m[`SDF_TRUNC_FIELD] = `SDF_TRUNC_ZERO;
    // sign goes back on last so the code is symmetric
    fine_fmt = sh[ACC_W-1] ? FINE_W'(-m) : m;
  endfunction

  // fast word: full scale 2**(2k) moved to bit 16
  function automatic logic [FAST_W-1:0] fast_fmt(
    input logic signed [FACC_W-1:0] v,
    input sdf_pkg::sdf_sel_t        sel
  );
    logic signed [FACC_W-1:0] sh;
    sh = v <<< (`SDF_FAST_SHIFT - {sel, 1'b0});
    fast_fmt = sh[FAST_W-1:0];
  endfunction

  sdf_regs u_regs (
    .clk         (clk),
    .nrst        (nrst),
    .reg_addr    (reg_addr),
    .reg_wdata   (reg_wdata),
    .reg_wr      (reg_wr),
    .reg_rd      (reg_rd),
    .reg_rdata   (reg_rdata),
    .gain_select (gain_select),
    .conv_setup  (conv_setup),
    .fine_result (fine_out_ff),
    .fast_result (fast_ext),
    .fine_valid  (fine_vld_ff),
    .input_short (short_ff)
  );

  assign fast_ext = {{(24-FAST_W){fast_out_ff[FAST_W-1]}}, fast_out_ff};

  // tap counts are powers of two, so the select is an exponent
  assign fine_log2 = `SDF_FINE_LOG2 + {2'b00, fine_sel_ff};
  assign fast_log2 = `SDF_FAST_LOG2 + {2'b00, fast_sel_ff};
  assign smp_en    = mod_bit_valid & on_ff;

  // fine filter, the slow high-resolution path
  sdf_sinc2 #(
    .W     (ACC_W),
    .CNT_W (14)
  ) u_fine_decimator (
    .clk      (clk),
    .nrst     (nrst),
    .restart  (restart),
    .smp_en   (smp_en),
    .smp_bit  (mod_bit),
    .tap_log2 (fine_log2),
    .sum      (fine_raw),
    .valid    (fine_dv)
  );

  // fast filter runs beside it on the same stream
  sdf_sinc2 #(
    .W     (FACC_W),
    .CNT_W (8)
  ) u_fast_decimator (
    .clk      (clk),
    .nrst     (nrst),
    .restart  (restart),
    .smp_en   (smp_en),
    .smp_bit  (mod_bit),
    .tap_log2 (fast_log2),
    .sum      (fast_raw),
    .valid    (fast_dv)
  );

  // settings, offset-cycle phase and modulator control
  always_comb
  begin
    nxt_on       = gain_select[`SDF_ON_BIT];
    nxt_fine_sel = conv_setup[`SDF_FINE_SEL];
    nxt_fast_sel = conv_setup[`SDF_FAST_SEL];
    nxt_cyc      = conv_setup[`SDF_CYC_SEL];
    change       = (nxt_on != on_ff) || (nxt_cyc != cyc_ff) ||
                   (nxt_fine_sel != fine_sel_ff) ||
                   (nxt_fast_sel != fast_sel_ff);
    // each half cycle spans 2N samples, one full fine window
    phase_last   = 16'((64'h2 << fine_log2) - 64'h1);
    nxt_phase    = phase_ff;
    nxt_pcnt     = pcnt_ff;
    flip         = 1'b0;
    if (cyc_ff == `SDF_CYC_CANCEL && smp_en)
    begin
      nxt_pcnt = pcnt_ff + 16'h0001;
      if (pcnt_ff == phase_last)
      begin
        flip     = 1'b1;
        nxt_pcnt = 16'h0000;
        unique case (phase_ff)
          sdf_pkg::SDF_PH_SHORT: nxt_phase = sdf_pkg::SDF_PH_INPUT;
          sdf_pkg::SDF_PH_INPUT: nxt_phase = sdf_pkg::SDF_PH_SHORT;
        endcase
      end
    end
    if (change)
    begin
      nxt_pcnt  = 16'h0000;
      nxt_phase = sdf_pkg::SDF_PH_SHORT;
    end
    // a half cycle must not see the other half's samples
    restart = change || !on_ff || flip;
    if (nxt_cyc == `SDF_CYC_OFFSET)
      nxt_short = 1'b1;
    else if (nxt_cyc == `SDF_CYC_CANCEL)
      nxt_short = (nxt_phase == sdf_pkg::SDF_PH_SHORT);
    else
      nxt_short = 1'b0;
  end

  // fine result: negate, pass, or cancel against the shorted half
  always_comb
  begin
    nxt_off      = off_ff;
    nxt_in       = in_ff;
    nxt_have_off = have_off_ff;
    nxt_have_in  = have_in_ff;
    fine_val     = fine_raw;
    fine_take    = 1'b0;
    if (fine_dv)
    begin
      if (cyc_ff == `SDF_CYC_OFFSET)
      begin
        fine_val  = -fine_raw;
        fine_take = 1'b1;
      end
      else if (cyc_ff == `SDF_CYC_CANCEL)
      begin
        // strobes trail the phase flip by a cycle, so use the old half
        if (dump_ph_ff == sdf_pkg::SDF_PH_SHORT)
        begin
          nxt_off      = fine_raw;
          nxt_have_off = 1'b1;
          fine_val     = in_ff - fine_raw;
          fine_take    = have_in_ff;
        end
        else
        begin
          nxt_in      = fine_raw;
          nxt_have_in = 1'b1;
          fine_val    = fine_raw - off_ff;
          fine_take   = have_off_ff;
        end
      end
      else
      begin
        fine_take = 1'b1;
      end
    end
    // held halves are dropped on a setting change or while off; a dump strobed the cycle after a change still loads
    if (change || !on_ff)
    begin
      nxt_have_off = 1'b0;
      nxt_have_in  = 1'b0;
    end
    nxt_fine_out = fine_out_ff;
    if (fine_take)
      nxt_fine_out = fine_fmt(fine_val, fine_sel_ff);
    nxt_fine_vld = fine_take;
  end

  // fast result: every dump, but only input halves when cancelling
  always_comb
  begin
    nxt_fast_out = fast_out_ff;
    nxt_fast_vld = 1'b0;
    if (fast_dv && (cyc_ff != `SDF_CYC_CANCEL ||
                    dump_ph_ff == sdf_pkg::SDF_PH_INPUT))
    begin
      nxt_fast_vld = 1'b1;
      if (cyc_ff == `SDF_CYC_OFFSET)
        nxt_fast_out = fast_fmt(-fast_raw, fast_sel_ff);
      else
        nxt_fast_out = fast_fmt(fast_raw, fast_sel_ff);
    end
  end

  // all block state; control registers reset to zero, so converter off
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      on_ff       <= 1'b0;
      fine_sel_ff <= 2'h0;
      fast_sel_ff <= 2'h0;
      cyc_ff      <= 2'h0;
      phase_ff    <= sdf_pkg::SDF_PH_SHORT;
      dump_ph_ff  <= sdf_pkg::SDF_PH_SHORT;
      pcnt_ff     <= 16'h0000;
      short_ff    <= 1'b0;
      off_ff      <= '0;
      in_ff       <= '0;
      have_off_ff <= 1'b0;
      have_in_ff  <= 1'b0;
      fine_out_ff <= '0;
      fine_vld_ff <= 1'b0;
      fast_out_ff <= '0;
      fast_vld_ff <= 1'b0;
    end
    else
    begin
      on_ff       <= nxt_on;
      fine_sel_ff <= nxt_fine_sel;
      fast_sel_ff <= nxt_fast_sel;
      cyc_ff      <= nxt_cyc;
      phase_ff    <= nxt_phase;
      dump_ph_ff  <= phase_ff;
      pcnt_ff     <= nxt_pcnt;
      short_ff    <= nxt_short;
      off_ff      <= nxt_off;
      in_ff       <= nxt_in;
      have_off_ff <= nxt_have_off;
      have_in_ff  <= nxt_have_in;
      fine_out_ff <= nxt_fine_out;
      fine_vld_ff <= nxt_fine_vld;
      fast_out_ff <= nxt_fast_out;
      fast_vld_ff <= nxt_fast_vld;
    end
  end

  // a pulse shorter than four fast periods is smeared, not caught
  assign converter_on = on_ff;
  assign input_short  = short_ff;
  assign fine_result  = fine_out_ff;
  assign fine_valid   = fine_vld_ff;
  assign fast_result  = fast_out_ff;
  assign fast_valid   = fast_vld_ff;
endmodule
`default_nettype wire

// >>> testbench/sdf_mod_model.sv
// Purpose: one-bit modulator stand-in feeding the filters
// Assumes: one bit per clock while the converter runs
// Notes:   a shorted input gives a fixed level, the offset extreme
`timescale 1ns/1ps
`default_nettype none
module sdf_mod_model (
  input  wire logic        clk,           // clock
  input  wire logic        nrst,          // reset, active low
  input  wire logic        converter_on,  // modulator powered
  input  wire logic        input_short,   // input shorted
  input  wire logic [15:0] pattern,       // repeating input bits
  input  wire logic        short_lvl,     // bit while shorted
  output logic             mod_bit,       // modulator bit
  output logic             mod_bit_valid  // bit strobe
);
  logic [3:0] idx_ff, nxt_idx;
  logic       tgl_ff, nxt_tgl;
  logic       vld_ff, nxt_vld;
  // pattern is held for whole windows, far past four fast periods
  always_comb
  begin
    nxt_idx = converter_on ? idx_ff + 4'h1 : 4'h0;
    nxt_tgl = ~tgl_ff;
    nxt_vld = converter_on;
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      idx_ff <= 4'h0;
      tgl_ff <= 1'b0;
      vld_ff <= 1'b0;
    end
    else
    begin
      idx_ff <= nxt_idx;
      tgl_ff <= nxt_tgl;
      vld_ff <= nxt_vld;
    end
  end
  // short follows at once; a stopped stream toggles so no bit looks stale
  assign mod_bit = !vld_ff ? tgl_ff :
                   (input_short ? short_lvl : pattern[idx_ff]);
  assign mod_bit_valid = vld_ff;
endmodule
`default_nettype wire

// >>> testbench/sdf_top_properties.sv
// Purpose: port properties of the decimation filter block
// Assumes: one clock domain, reset low
// Notes:   bound into sdf_top
`timescale 1ns/1ps
`default_nettype none
module sdf_top_chk #(
  parameter sdf_pkg::sdf_model_t MODEL  = sdf_pkg::SDF_MODEL_50K,
  parameter int                  FINE_W = 24,
  parameter int                  FAST_W = 18
) (
  input wire logic              clk,           // clock
  input wire logic              nrst,          // reset
  input wire logic [7:0]        reg_addr,      // address
  input wire logic [7:0]        reg_wdata,     // write data
  input wire logic              reg_wr,        // write strobe
  input wire logic              reg_rd,        // read strobe
  input wire logic [7:0]        reg_rdata,     // read data
  input wire logic              mod_bit,       // stream bit
  input wire logic              mod_bit_valid, // stream strobe
  input wire logic              converter_on,  // run
  input wire logic              input_short,   // short
  input wire logic [FINE_W-1:0] fine_result,   // fine word
  input wire logic              fine_valid,    // fine strobe
  input wire logic [FAST_W-1:0] fast_result,   // fast word
  input wire logic              fast_valid     // fast strobe
);
  // the 20k variant clips earlier than the others
  localparam logic [3:0] LIM = MODEL == sdf_pkg::SDF_MODEL_20K ? 4'h5 : 4'ha;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_on; reg_wr && reg_addr == 8'h05 |->
    ##2 converter_on == $past(reg_wdata[7], 2); endproperty
  a_on: assert property (p_on) else $error("run bit lags");
  property p_short; reg_wr && reg_addr == 8'h06 && reg_wdata[5:4] != 2'b01
    |-> ##2 input_short == ($past(reg_wdata[5:4], 2) == 2'b00); endproperty
  a_short: assert property (p_short) else $error("short wrong");
  property p_back; reg_wr && reg_addr == 8'h06 ##1 reg_rd && reg_addr ==
    8'h06 |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_back: assert property (p_back) else $error("setup readback");
  property p_fine1; fine_valid |=> !fine_valid [*8]; endproperty
  a_fine1: assert property (p_fine1) else $error("fine strobe");
  property p_fast1; fast_valid |=> !fast_valid [*8]; endproperty
  a_fast1: assert property (p_fast1) else $error("fast strobe");
  property p_off; !converter_on [*3] |-> !fine_valid && !fast_valid;
  endproperty
  a_off: assert property (p_off) else $error("result while off");
  property p_hold; !fine_valid && converter_on && $past(converter_on)
    |-> $stable(fine_result); endproperty
  a_hold: assert property (p_hold) else $error("fine word moved");
  property p_sat; fine_valid && !fine_result[FINE_W-1] |->
    fine_result[21:18] <= LIM || fine_result[21:18] == 4'hf; endproperty
  a_sat: assert property (p_sat) else $error("no clipping");
  c_fine: cover property (fine_valid);
  c_short: cover property (fast_valid && input_short);
  c_back: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule
bind sdf_top sdf_top_chk #(.MODEL(MODEL), .FINE_W(FINE_W), .FAST_W(FAST_W))
  u_chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .mod_bit(mod_bit), .mod_bit_valid(mod_bit_valid),
  .converter_on(converter_on), .input_short(input_short),
  .fine_result(fine_result), .fine_valid(fine_valid),
  .fast_result(fast_result), .fast_valid(fast_valid));
`default_nettype wire

// >>> testbench/test_sdf_top.sv
// Purpose: self-checking bench of the decimation filter block
// Assumes: 125 MHz clock, one modulator bit per cycle while on
// Notes:   a first fine word needs two windows, so runs are long
`include "sdf_map.svh"
`timescale 1ns/1ps
`default_nettype none
module test_sdf_top;
  logic        clk, nrst, reg_wr, reg_rd, short_lvl;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        mod_bit, mod_bit_valid, converter_on, input_short;
  logic        fine_valid, fast_valid;
  logic [23:0] fine_result;
  logic [17:0] fast_result;
  logic [15:0] pattern;
  int          failures, check_count;
  sdf_top u_dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mod_bit(mod_bit), .mod_bit_valid(mod_bit_valid),
    .converter_on(converter_on), .input_short(input_short),
    .fine_result(fine_result), .fine_valid(fine_valid),
    .fast_result(fast_result), .fast_valid(fast_valid));
  sdf_mod_model u_mod (.clk(clk), .nrst(nrst), .converter_on(converter_on),
    .input_short(input_short), .pattern(pattern), .short_lvl(short_lvl),
    .mod_bit(mod_bit), .mod_bit_valid(mod_bit_valid));
  always #4 clk = ~clk;
  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, exp, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 check(nm, reg_rdata, exp);
  endtask
  // bounded wait for a strobe; n counts the edges passed
  task automatic await(input logic fast, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end
    while ((fast ? fast_valid : fine_valid) !== 1'b1 && n < lim);
  endtask
  // restart from off so no window mixes two settings
  task automatic run(input logic [7:0] setup, input logic [15:0] pat,
    input logic [23:0] f_exp, input logic [17:0] q_exp, input int fn, qn);
    int n;
    wr(`SDF_ADDR_GAIN, 8'h00);
    pattern <= pat;
    wr(`SDF_ADDR_SETUP, setup);
    wr(`SDF_ADDR_GAIN, 8'h80);
    await(1'b0, 4 * fn + 16, n);
    check("fine_valid", fine_valid, 1'b1);
    check("fine_result", fine_result, f_exp);
    await(1'b0, fn + 16, n);
    check("fine period", n, fn);
    if (qn > 0)
    begin
      check("fast_result", fast_result, q_exp);
      await(1'b1, qn + 16, n);
      await(1'b1, qn + 16, n);
      check("fast period", n, qn);
      check("input_short", input_short, setup[5:4] == 2'b00);
      rd(`SDF_ADDR_STAT, {5'h00, 2'b11, setup[5:4] == 2'b00}, "stat");
      rd(`SDF_ADDR_STAT, {5'h00, 2'b01, setup[5:4] == 2'b00}, "stat2");
      rd(`SDF_ADDR_FINE2, f_exp[23:16], "fine hi");
    end
  endtask
  task automatic sc_regs();
    rd(`SDF_ADDR_GAIN, 8'h00, "gain rst");
    rd(`SDF_ADDR_STAT, 8'h01, "stat rst");
    @(posedge clk);
    reg_addr  <= `SDF_ADDR_SETUP;
    reg_wdata <= 8'hf6;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge clk);
    reg_rd    <= 1'b0;
    #1 check("setup", reg_rdata, 8'hf6);
    wr(8'h21, 8'h55);
    rd(8'h21, 8'h00, "unmapped");
    wr(`SDF_ADDR_GAIN, 8'h80);
    rd(`SDF_ADDR_STAT, 8'h02, "stat on");
    check("converter_on", converter_on, 1'b1);
  endtask
  // every fast tap code, but fine only selects 00 and 01, to bound run time
  task automatic sc_taps();
    for (int k = 0; k < 4; k++)
      run({4'h3, k[1:0], 1'b0, k[0]}, 16'hffff, 24'h400000, 18'h10000,
          2048 << k[0], 32 << k);
  endtask
  task automatic sc_modes();
    run(8'h20, 16'h0000, 24'hc00000, 18'h30000, 2048, 32);
    short_lvl <= 1'b0;
    run(8'h00, 16'hffff, 24'h400000, 18'h10000, 2048, 32);
    short_lvl <= 1'b1;
    run(8'h10, 16'h0fff, 24'he00000, 18'h00000, 4096, 0);
    run(8'h30, 16'h3fff, 24'h3c0000, 18'h0c000, 2048, 32);
  endtask
  task automatic sc_off();
    int n;
    wr(`SDF_ADDR_GAIN, 8'h00);
    await(1'b0, 6000, n);
    check("fine_valid off", fine_valid, 1'b0);
    check("converter_on off", converter_on, 1'b0);
  endtask
  task automatic conclude();
    if (failures == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge clk);
    failures++;
    conclude();
  end
  initial
  begin
    clk         = 1'b0;
    nrst        = 1'b0;
    reg_addr    = 8'h00;
    reg_wdata   = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    pattern     = 16'hffff;
    short_lvl   = 1'b1;
    failures    = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    sc_regs();
    sc_taps();
    sc_modes();
    sc_off();
    conclude();
  end
endmodule
`default_nettype wire
